// *** bench/tb.sv ***
// Self-checking bench for the thermal and clock output register bank.
`timescale 1ns/1ps
`include "tac_params.svh"

module tb;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_rd = 1'b0;
    logic hot_die_raw = 1'b0;
    logic shutdown_reached_raw = 1'b0;
    logic seq_clkout_step = 1'b0;
    logic [7:0] reg_rdata_ff;
    logic reg_rvalid_ff;
    tac_pkg::tac_hd_thr_t hot_die_threshold_select_ff;
    logic shutdown_module_enable_ff;
    logic slow_clock_output_enable_ff;
    logic [7:0] exp_q[$];
    logic [7:0] th_m = `TAC_THERMAL_RESET;
    logic ck_m = `TAC_CLK_EN_RESET;
    logic [7:0] e;
    logic [1:0] raw_tab[4] = '{2'h2, 2'h1, 2'h3, 2'h0};
    int error_cnt = 0;
    int total_checks = 0;
    int cycles = 0;
    int seed = 32'h47025607;

    // The clock toggles every half period of 5 ns.
    always #5 clock = ~clock;

    // The sequencer option is on so that the power-up step can be seen.
    tac_regs #(.AUTO_CLKOUT_IN_SEQ(1'b1)) tac_regs_i (
        .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata_ff(reg_rdata_ff), .reg_rvalid_ff(reg_rvalid_ff),
        .hot_die_raw(hot_die_raw),
        .shutdown_reached_raw(shutdown_reached_raw),
        .hot_die_threshold_select_ff(hot_die_threshold_select_ff),
        .shutdown_module_enable_ff(shutdown_module_enable_ff),
        .seq_clkout_step(seq_clkout_step),
        .slow_clock_output_enable_ff(slow_clock_output_enable_ff));

    // Compares one value and counts the outcome.
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Prints the counts and the verdict, then stops the run.
    task results;
        $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results

    // Expected thermal image from the model and the detector levels.
    function automatic logic [7:0] img();
        return {2'h0, hot_die_raw, shutdown_reached_raw, th_m[3:2], 1'b0,
            th_m[0]};
    endfunction : img

    // Expected read data for any address.
    function automatic logic [7:0] rexp(input logic [7:0] a);
        if (a == `TAC_THERMAL_OFFSET) return img();
        if (a == `TAC_CLKOUT_OFFSET) return {7'h00, ck_m};
        return `TAC_UNMAPPED_DATA;
    endfunction : rexp

    // One register port cycle; a read leaves its expected byte queued.
    task bus(input logic w, input logic r, input logic [7:0] a,
        input logic [7:0] wd, input logic [7:0] ex);
        reg_wr = w;
        reg_rd = r;
        reg_addr = a;
        reg_wdata = wd;
        if (r) exp_q.push_back(ex);
        @(posedge clock);
        #1;
    endtask : bus

    // Updates the model after a write has been taken.
    task upd(input logic [7:0] a, input logic [7:0] wd);
        if (a == `TAC_THERMAL_OFFSET) th_m = wd & 8'h0D;
        if (a == `TAC_CLKOUT_OFFSET) ck_m = wd[0];
    endtask : upd

    // Compares the control outputs with the model.
    task ctl;
        chk({6'h00, hot_die_threshold_select_ff},
            {6'h00, th_m[3:2]});
        chk({7'h00, shutdown_module_enable_ff}, {7'h00, th_m[0]});
        chk({7'h00, slow_clock_output_enable_ff}, {7'h00, ck_m});
    endtask : ctl

    // Writes a byte, checks the outputs, then reads it back at once.
    task wrchk(input logic [7:0] a, input logic [7:0] wd);
        bus(1'b1, 1'b0, a, wd, 8'h00);
        upd(a, wd);
        ctl();
        bus(1'b0, 1'b1, a, 8'h00, rexp(a));
    endtask : wrchk

    // Each read answer is matched against the oldest queued byte.
    always @(negedge clock) begin
        if (reg_rvalid_ff === 1'b1) begin
            if (exp_q.size() == 0) begin
                error_cnt++;
                $display("Error at %0t: read answer with none pending", $time);
            end else begin
                chk(reg_rdata_ff, exp_q.pop_front());
            end
        end
    end

    // Cuts a hung run short.
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            $display("Error at %0t: run did not finish", $time);
            results();
        end
    end

    // Main sequence of scenarios.
    initial begin
        repeat (20) @(posedge clock);
        #1;
        rst_n = 1'b1;
        ctl();
        bus(1'b0, 1'b1, 8'h22, 8'h00, 8'h0D);
        bus(1'b0, 1'b1, 8'h23, 8'h00, 8'h00);
        wrchk(8'h22, 8'hFF);
        wrchk(8'h24, 8'hFF);
        for (int i = 0; i < 4; i++) begin
            wrchk(8'h22, {4'h0, i[1:0], 1'b0, i[0]});
        end
        for (int k = 0; k < 4; k++) begin
            e = img();
            {hot_die_raw, shutdown_reached_raw} = raw_tab[k];
            bus(1'b0, 1'b1, 8'h22, 8'h00, e);
            bus(1'b0, 1'b1, 8'h22, 8'h00, e);
            bus(1'b0, 1'b1, 8'h22, 8'h00, img());
        end
        wrchk(8'h23, 8'hFF);
        wrchk(8'h23, 8'h00);
        seq_clkout_step = 1'b1;
        bus(1'b1, 1'b0, 8'h23, 8'h00, 8'h00);
        seq_clkout_step = 1'b0;
        ck_m = 1'b1;
        ctl();
        for (int n = 0; n < 24; n++) begin
            e = 8'h22 + 8'($random(seed) & 3);
            bus(1'b1, 1'b1, e, 8'($random(seed)), rexp(e));
            upd(e, reg_wdata);
            ctl();
        end
        rst_n = 1'b0;
        repeat (3) bus(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
        rst_n = 1'b1;
        th_m = `TAC_THERMAL_RESET;
        ck_m = `TAC_CLK_EN_RESET;
        ctl();
        bus(1'b0, 1'b1, 8'h22, 8'h00, 8'h0D);
        bus(1'b0, 1'b1, 8'h23, 8'h00, 8'h00);
        repeat (2) bus(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
        chk(8'(exp_q.size()), 8'h00);
        results();
    end
endmodule : tb

// *** verilog/tac_params.svh ***
// Offsets, field positions, reset values and timing counts of the bank.
`ifndef TAC_PARAMS_SVH
`define TAC_PARAMS_SVH

// Register offsets on the serial register port.
`define TAC_ADDR_W 8
`define TAC_THERMAL_OFFSET 8'h22
`define TAC_CLKOUT_OFFSET 8'h23

// Thermal register field positions.
`define TAC_HD_FLAG_BIT 5
`define TAC_TS_FLAG_BIT 4
`define TAC_HDSEL_HI 3
`define TAC_HDSEL_LO 2
`define TAC_TS_EN_BIT 0

// Clock output register field position.
`define TAC_CLK_EN_BIT 0

// Reset values.
`define TAC_THERMAL_RESET 8'h0D
`define TAC_HDSEL_RESET 2'h3
`define TAC_TS_EN_RESET 1'h1
`define TAC_CLK_EN_RESET 1'h0

// Read data for an address outside the two registers.
`define TAC_UNMAPPED_DATA 8'h00

// Flip-flop stages on each detector input.
`define TAC_SYNC_STAGES 2

`endif

// *** verilog/tac_pkg.sv ***
// Types shared by the thermal and clock output register bank.
package tac_pkg;

    // Hot-die detector threshold codes.
    typedef enum logic [1:0] {
        TAC_HD_117C = 2'h0,
        TAC_HD_121C = 2'h1,
        TAC_HD_125C = 2'h2,
        TAC_HD_130C = 2'h3
    } tac_hd_thr_t;

    // Register selected by the access address.
    typedef enum logic [1:0] {
        TAC_SEL_NONE = 2'h0,
        TAC_SEL_THERMAL = 2'h1,
        TAC_SEL_CLKOUT = 2'h3
    } tac_reg_sel_t;

endpackage : tac_pkg

// *** verilog/tac_regs.sv ***
// Thermal monitor and slow clock output control registers.
`timescale 1ns/1ps
`include "tac_params.svh"

module tac_regs #(
    parameter bit AUTO_CLKOUT_IN_SEQ = 1'b0
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_n,
    // Register access port from the serial interface.
    input wire logic [`TAC_ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata_ff,
    output logic reg_rvalid_ff,
    // Analog detectors.
    input wire logic hot_die_raw,
    input wire logic shutdown_reached_raw,
    output tac_pkg::tac_hd_thr_t hot_die_threshold_select_ff,
    output logic shutdown_module_enable_ff,
    // Power-up sequencer step and clock output gate.
    input wire logic seq_clkout_step,
    output logic slow_clock_output_enable_ff
);

    logic [1:0] det_sync;
    logic hot_die_flag;
    logic shutdown_reached_flag;
    tac_pkg::tac_reg_sel_t sel;
    logic wr_thermal;
    logic wr_clkout;
    logic auto_set;
    logic [7:0] thermal_view;
    logic [7:0] clkout_view;
    logic [7:0] nxt_rdata;

    // Detector levels are asynchronous to the register clock.
    tac_sync2 #(
        .WIDTH(2)
    ) u_det_sync (
        .clock(clock),
        .rst_n(rst_n),
        .async_in({hot_die_raw, shutdown_reached_raw}),
        .sync_out(det_sync)
    );

    // Synchronised flags as software sees them.
    assign hot_die_flag = det_sync[1];
    assign shutdown_reached_flag = det_sync[0];

    // Address decode of the access port.
    always_comb begin
        unique case (reg_addr)
            `TAC_THERMAL_OFFSET: sel = tac_pkg::TAC_SEL_THERMAL;
            `TAC_CLKOUT_OFFSET: sel = tac_pkg::TAC_SEL_CLKOUT;
            default: sel = tac_pkg::TAC_SEL_NONE;
        endcase
    end

    // Write strobes per register.
    assign wr_thermal = reg_wr && (sel == tac_pkg::TAC_SEL_THERMAL);
    assign wr_clkout = reg_wr && (sel == tac_pkg::TAC_SEL_CLKOUT);
    assign auto_set = AUTO_CLKOUT_IN_SEQ && seq_clkout_step;

    // Threshold select; only bits 3:2 of a write are kept.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            hot_die_threshold_select_ff <=
                tac_pkg::tac_hd_thr_t'(`TAC_HDSEL_RESET);
        end else if (wr_thermal) begin
            hot_die_threshold_select_ff <= tac_pkg::tac_hd_thr_t'(
                reg_wdata[`TAC_HDSEL_HI:`TAC_HDSEL_LO]);
        end
    end

    // Shutdown module enable; status and reserved bits are dropped.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            shutdown_module_enable_ff <= `TAC_TS_EN_RESET;
        end else if (wr_thermal) begin
            shutdown_module_enable_ff <=
                reg_wdata[`TAC_TS_EN_BIT];
        end
    end

    // Clock output gate; the sequencer step wins over a clearing write.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            slow_clock_output_enable_ff <= `TAC_CLK_EN_RESET;
        end else if (auto_set) begin
            slow_clock_output_enable_ff <= 1'h1;
        end else if (wr_clkout) begin
            slow_clock_output_enable_ff <=
                reg_wdata[`TAC_CLK_EN_BIT];
        end
    end

    // Read images with reserved bits forced low.
    always_comb begin
        thermal_view = 8'h00;
        thermal_view[`TAC_HD_FLAG_BIT] = hot_die_flag;
        thermal_view[`TAC_TS_FLAG_BIT] = shutdown_reached_flag;
        thermal_view[`TAC_HDSEL_HI:`TAC_HDSEL_LO] =
            hot_die_threshold_select_ff;
        thermal_view[`TAC_TS_EN_BIT] = shutdown_module_enable_ff;
        clkout_view = 8'h00;
        clkout_view[`TAC_CLK_EN_BIT] = slow_clock_output_enable_ff;
    end

    // Read data mux.
    always_comb begin
        unique case (sel)
            tac_pkg::TAC_SEL_THERMAL: nxt_rdata = thermal_view;
            tac_pkg::TAC_SEL_CLKOUT: nxt_rdata = clkout_view;
            default: nxt_rdata = `TAC_UNMAPPED_DATA;
        endcase
    end

    // Read answer one cycle after the strobe; data holds until the next read.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            reg_rdata_ff <= 8'h00;
            reg_rvalid_ff <= 1'h0;
        end else begin
            reg_rvalid_ff <= reg_rd;
            if (reg_rd) begin
                reg_rdata_ff <= nxt_rdata;
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // Reserved thermal bits read zero.
    thermal_reserved_bit_zero_a: assert property (
        reg_rd && reg_addr == `TAC_THERMAL_OFFSET |=>
            reg_rvalid_ff && reg_rdata_ff[7:6] == 2'h0
            && reg_rdata_ff[1] == 1'h0)
        else $error("thermal reserved bits not zero");

    // Reserved clock output bits read zero.
    clkout_reserved_bit_zero_a: assert property (
        reg_rd && reg_addr == `TAC_CLKOUT_OFFSET |=>
            reg_rdata_ff[7:1] == 7'h00)
        else $error("clock output reserved bits not zero");

    // A write stores exactly the writable thermal fields.
    thermal_write_store_a: assert property (
        wr_thermal |=> hot_die_threshold_select_ff == $past(reg_wdata[3:2])
            && shutdown_module_enable_ff == $past(reg_wdata[0]))
        else $error("thermal write not stored");

    // Hot-die bit reads the synchronised detector level.
    hot_flag_read_a: assert property (
        reg_rd && reg_addr == `TAC_THERMAL_OFFSET
            && $past(rst_n) && $past(rst_n, 2) |=>
            reg_rdata_ff[5] == $past(hot_die_raw, 3))
        else $error("hot-die bit wrong");

    // Shutdown bit reads the synchronised detector level.
    shutdown_flag_read_a: assert property (
        reg_rd && reg_addr == `TAC_THERMAL_OFFSET
            && $past(rst_n) && $past(rst_n, 2) |=>
            reg_rdata_ff[4] == $past(shutdown_reached_raw, 3))
        else $error("shutdown bit wrong");

    // Threshold only moves on a thermal write.
    threshold_hold_a: assert property (
        !wr_thermal |=> $stable(hot_die_threshold_select_ff))
        else $error("threshold changed without write");

    // Shutdown enable only moves on a thermal write.
    shutdown_enable_hold_a: assert property (
        !wr_thermal |=> $stable(shutdown_module_enable_ff))
        else $error("shutdown enable changed without write");

    // Clock gate follows a write when no sequencer step coincides.
    clkout_write_a: assert property (
        wr_clkout && !auto_set |=>
            slow_clock_output_enable_ff == $past(reg_wdata[0]))
        else $error("clock output enable not written");

    // Sequencer step sets the gate in configured variants.
    clkout_auto_set_a: assert property (
        AUTO_CLKOUT_IN_SEQ && seq_clkout_step |=>
            slow_clock_output_enable_ff)
        else $error("sequencer step did not enable clock");

    // Values right after reset release.
    reset_defaults_a: assert property (
        $rose(rst_n) |-> hot_die_threshold_select_ff == tac_pkg::TAC_HD_130C
            && shutdown_module_enable_ff && !slow_clock_output_enable_ff)
        else $error("reset defaults wrong");

    // Detector levels reach the flags two edges later.
    sync_latency_a: assert property (
        ##2 1'b1 |-> det_sync == $past({hot_die_raw,
            shutdown_reached_raw}, 2))
        else $error("synchroniser latency wrong");

    // Every read strobe is answered on the next edge.
    read_answer_a: assert property (
        reg_rd |=> reg_rvalid_ff)
        else $error("read not answered");

    // No answer appears without a read strobe.
    rvalid_pulse_a: assert property (
        !reg_rd |=> !reg_rvalid_ff)
        else $error("read answer without strobe");

    // Read data stands until the next read.
    rdata_hold_a: assert property (
        !reg_rd |=> $stable(reg_rdata_ff))
        else $error("read data moved without read");

    // Addresses outside the two registers read as zero.
    unmapped_read_a: assert property (
        reg_rd && sel == tac_pkg::TAC_SEL_NONE |=>
            reg_rdata_ff == `TAC_UNMAPPED_DATA)
        else $error("unmapped read not zero");

    // The threshold field reads back as stored before the edge.
    threshold_read_a: assert property (
        reg_rd && reg_addr == `TAC_THERMAL_OFFSET |=>
            reg_rdata_ff[3:2] == $past(hot_die_threshold_select_ff))
        else $error("threshold read back wrong");

    // The shutdown enable reads back as stored before the edge.
    enable_read_a: assert property (
        reg_rd && reg_addr == `TAC_THERMAL_OFFSET |=>
            reg_rdata_ff[0] == $past(shutdown_module_enable_ff))
        else $error("shutdown enable read back wrong");

    // The clock output enable reads back as stored before the edge.
    clkout_read_a: assert property (
        reg_rd && reg_addr == `TAC_CLKOUT_OFFSET |=>
            reg_rdata_ff[0] == $past(slow_clock_output_enable_ff))
        else $error("clock output enable read back wrong");

    // The clock gate holds unless written or set by the sequencer.
    clkout_hold_a: assert property (
        !wr_clkout && !auto_set |=>
            $stable(slow_clock_output_enable_ff))
        else $error("clock output enable changed unasked");

    // Writes outside the two registers change no control output.
    unmapped_write_a: assert property (
        reg_wr && sel == tac_pkg::TAC_SEL_NONE && !auto_set |=>
            $stable(hot_die_threshold_select_ff)
            && $stable(shutdown_module_enable_ff)
            && $stable(slow_clock_output_enable_ff))
        else $error("unmapped write changed a control");

    // A write alone never produces a read answer.
    write_no_read_a: assert property (
        reg_wr && !reg_rd |=>
            !reg_rvalid_ff)
        else $error("write produced a read answer");

    // A sequencer step beats a clearing write in the same cycle.
    step_beats_clear_a: assert property (
        auto_set && wr_clkout |=> slow_clock_output_enable_ff)
        else $error("clearing write beat sequencer step");

    // Reset holds every output at its default, checked inside reset.
    reset_values_a: assert property (
        disable iff (1'b0)
        !rst_n |=>
            hot_die_threshold_select_ff == tac_pkg::TAC_HD_130C
            && shutdown_module_enable_ff
            && !slow_clock_output_enable_ff
            && !reg_rvalid_ff && reg_rdata_ff == 8'h00)
        else $error("outputs not at defaults in reset");

    // Read port is idle and cleared at reset release.
    rvalid_release_a: assert property (
        $rose(rst_n) |->
            !reg_rvalid_ff && reg_rdata_ff == 8'h00)
        else $error("read port not cleared at release");

    // Reset clears both synchroniser chains.
    sync_reset_a: assert property (
        disable iff (1'b0)
        !rst_n |=> det_sync == 2'h0)
        else $error("synchroniser not cleared by reset");

    // The synchronised flags start low when reset is released.
    sync_release_a: assert property (
        $rose(rst_n) |->
            det_sync == 2'h0)
        else $error("synchroniser not low at release");

endmodule : tac_regs

// *** verilog/tac_sync2.sv ***
// Two flip-flop synchroniser, one chain per bit.
`timescale 1ns/1ps
`include "tac_params.svh"

module tac_sync2 #(
    parameter int WIDTH = 2
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_n,
    // Asynchronous levels in, synchronised levels out.
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    genvar i;

    // Each bit gets its own chain; the first stage feeds only the second.
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_chain
            logic meta_ff;
            logic stable_ff;

            // The first stage may go metastable and is read only below.
            always_ff @(posedge clock) begin
                if (!rst_n) begin
                    meta_ff <= 1'h0;
                    stable_ff <= 1'h0;
                end else begin
                    meta_ff <= async_in[i];
                    stable_ff <= meta_ff;
                end
            end

            assign sync_out[i] = stable_ff;
        end
    endgenerate

endmodule : tac_sync2
